// [rtl/ssw_supervisor.sv]
// Reset generation, watchdog and power-fail logic of a supply supervisor
// Functional notes
// - Secondary reset is low while either supply is low or manual reset is low.
// - Secondary reset stays low one reset timeout after all its causes clear.
// - Manual reset low holds reset, then a further timeout after it rises.
// - No strobe edge within the watchdog timeout asserts primary reset for one timeout.
// - The watchdog timer clears on any reset and on every strobe edge.
// - Long watchdog period after each reset, short after the first strobe edge.
// - A floating strobe input disables the watchdog entirely.
// - Auxiliary monitor below reference asserts primary reset with the same timeout.
// - Primary reset is low on any supply, aux, manual or watchdog cause.
// - A cause returning during the timeout restarts the timeout from zero.
// - Power-fail flag follows its input low and high one clock later, with no timeout.
`timescale 1ns/1ps
module ssw_supervisor #(
  parameter int unsigned TICK_CYCLES    = ssw_pkg::TICK_CYCLES,
  parameter int unsigned RESET_TICKS    = ssw_pkg::RESET_TMO_MS,
  parameter int unsigned WD_LONG_TICKS  = ssw_pkg::WD_LONG_MS,
  parameter int unsigned WD_SHORT_TICKS = ssw_pkg::WD_SHORT_MS
) (
  // Clock and reset
  input  wire logic                   CLOCK,
  input  wire logic                   RST_N,
  // Digitised comparator results
  input  wire ssw_pkg::ssw_mon_s      MON_BELOW,
  input  wire logic                   MANUAL_RESET_N,
  // Watchdog strobe, sensed as float, low or high
  input  wire ssw_pkg::ssw_wd_level_e WATCHDOG_STROBE_IN,
  // Outputs
  output logic                        PRIMARY_RESET_N,
  output logic                        SECONDARY_RESET_N,
  output logic                        POWERFAIL_FLAG_N
);

  ////////////////////////////////////////////////////////////////////////////
  // Time base

  logic tick;

  ssw_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .CLOCK (CLOCK),
    .RST_N (RST_N),
    .tick  (tick)
  );

  function automatic logic [ssw_pkg::TMO_W-1:0] tmo(input int unsigned v);
    tmo = ssw_pkg::TMO_W'(v);
  endfunction

  localparam logic [ssw_pkg::TMO_W-1:0] RST_LEN   = tmo(RESET_TICKS);
  localparam logic [ssw_pkg::TMO_W-1:0] WD_LONG   = tmo(WD_LONG_TICKS);
  localparam logic [ssw_pkg::TMO_W-1:0] WD_SHORT  = tmo(WD_SHORT_TICKS);

  ////////////////////////////////////////////////////////////////////////////
  // Cause decode

  logic sec_cause;
  logic pri_cause;
  logic wd_fire;

  always_comb begin
    sec_cause = MON_BELOW.primary_low | MON_BELOW.secondary_low | ~MANUAL_RESET_N;
    pri_cause = sec_cause | MON_BELOW.aux_low;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Primary reset sequencer

  ssw_pkg::ssw_state_e       pst_q;
  ssw_pkg::ssw_state_e       pst_d;
  logic [ssw_pkg::TMO_W-1:0] pcnt_q;
  logic [ssw_pkg::TMO_W-1:0] pcnt_d;

  always_comb begin
    pst_d  = pst_q;
    pcnt_d = pcnt_q;
    case (pst_q)
      ssw_pkg::SSW_HOLD: begin
        pcnt_d = ssw_pkg::CNT_RST;
        if (!pri_cause) begin
          pst_d = ssw_pkg::SSW_TIMEOUT;
        end
      end
      ssw_pkg::SSW_TIMEOUT: begin
        if (pri_cause) begin
          pst_d  = ssw_pkg::SSW_HOLD;
          pcnt_d = ssw_pkg::CNT_RST;
        end else if (tick) begin
          pcnt_d = pcnt_q + 1'b1;
          // One extra tick, a partial first tick never shortens it
          if (pcnt_d > RST_LEN) begin
            pst_d = ssw_pkg::SSW_RUN;
          end
        end
      end
      ssw_pkg::SSW_RUN: begin
        pcnt_d = ssw_pkg::CNT_RST;
        if (pri_cause) begin
          pst_d = ssw_pkg::SSW_HOLD;
        end else if (wd_fire) begin
          pst_d = ssw_pkg::SSW_TIMEOUT;
        end
      end
      default: begin
        pst_d  = ssw_pkg::SSW_HOLD;
        pcnt_d = ssw_pkg::CNT_RST;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pst_q  <= ssw_pkg::SSW_HOLD;
      pcnt_q <= ssw_pkg::CNT_RST;
    end else begin
      pst_q  <= pst_d;
      pcnt_q <= pcnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Secondary reset sequencer

  logic                      shold_q;
  logic                      shold_d;
  logic [ssw_pkg::TMO_W-1:0] scnt_q;
  logic [ssw_pkg::TMO_W-1:0] scnt_d;

  always_comb begin
    shold_d = shold_q;
    scnt_d  = scnt_q;
    if (sec_cause) begin
      shold_d = 1'b1;
      scnt_d  = ssw_pkg::CNT_RST;
    end else if (shold_q && tick) begin
      scnt_d = scnt_q + 1'b1;
      if (scnt_d > RST_LEN) begin
        shold_d = 1'b0;
        scnt_d  = ssw_pkg::CNT_RST;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      shold_q <= 1'b1;
      scnt_q  <= ssw_pkg::CNT_RST;
    end else begin
      shold_q <= shold_d;
      scnt_q  <= scnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog

  logic                      wd_prev_q;
  logic                      wd_prev_d;
  logic                      wd_short_q;
  logic                      wd_short_d;
  logic [ssw_pkg::TMO_W-1:0] wcnt_q;
  logic [ssw_pkg::TMO_W-1:0] wcnt_d;
  logic                      wd_level;
  logic                      wd_edge;
  logic                      wd_float;

  always_comb begin
    wd_float   = (WATCHDOG_STROBE_IN == ssw_pkg::SSW_WD_FLOAT);
    wd_level   = (WATCHDOG_STROBE_IN == ssw_pkg::SSW_WD_HIGH);
    wd_edge    = !wd_float && (wd_level != wd_prev_q);
    wd_prev_d  = wd_float ? wd_prev_q : wd_level;
    wd_short_d = wd_short_q;
    wd_fire    = 1'b0;
    wcnt_d     = wcnt_q;
    if (pst_q != ssw_pkg::SSW_RUN) begin
      wcnt_d     = ssw_pkg::CNT_RST;
      wd_short_d = 1'b0;
    end else if (wd_float) begin
      wcnt_d = ssw_pkg::CNT_RST;
    end else if (wd_edge) begin
      wcnt_d     = ssw_pkg::CNT_RST;
      wd_short_d = 1'b1;
    end else if (tick) begin
      wcnt_d = wcnt_q + 1'b1;
      wd_fire = (wcnt_d > (wd_short_q ? WD_SHORT : WD_LONG));
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      wd_prev_q  <= 1'b0;
      wd_short_q <= 1'b0;
      wcnt_q     <= ssw_pkg::CNT_RST;
    end else begin
      wd_prev_q  <= wd_prev_d;
      wd_short_q <= wd_short_d;
      wcnt_q     <= wcnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers

  logic pri_n_d;
  logic sec_n_d;
  logic pf_n_d;

  always_comb begin
    pri_n_d = (pst_d == ssw_pkg::SSW_RUN);
    sec_n_d = !shold_d;
    pf_n_d  = !MON_BELOW.pf_low;
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      PRIMARY_RESET_N   <= 1'b0;
      SECONDARY_RESET_N <= 1'b0;
      POWERFAIL_FLAG_N  <= 1'b0;
    end else begin
      PRIMARY_RESET_N   <= pri_n_d;
      SECONDARY_RESET_N <= sec_n_d;
      POWERFAIL_FLAG_N  <= pf_n_d;
    end
  end

endmodule

// [rtl/ssw_tick.sv]
// Millisecond time base divider
`timescale 1ns/1ps
module ssw_tick #(
  // Clocks per tick, must fit the TICK_W counter
  parameter int unsigned TICK_CYCLES = ssw_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic CLOCK,
  input  wire logic RST_N,
  // Tick output
  output logic      tick
);

  logic [ssw_pkg::TICK_W-1:0] cnt_q;
  logic [ssw_pkg::TICK_W-1:0] cnt_d;
  logic                       tick_q;
  logic                       tick_d;

  localparam logic [ssw_pkg::TICK_W-1:0] LAST =
    ssw_pkg::TICK_W'(TICK_CYCLES - 1);

  always_comb begin
    tick_d = (cnt_q == LAST);
    cnt_d  = tick_d ? ssw_pkg::TICK_RST : cnt_q + 1'b1;
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_q  <= ssw_pkg::TICK_RST;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule

// [shared/ssw_pkg.sv]
// Package for the supply supervisor reset and watchdog block
package ssw_pkg;

  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned TICK_NS        = 1000000;
  localparam int unsigned TICK_CYCLES    = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_W         = 14;

  // Timeouts in milliseconds, as printed
  localparam int unsigned RESET_TMO_MS   = 1120;
  localparam int unsigned WD_LONG_MS     = 35000;
  localparam int unsigned WD_SHORT_MS    = 1120;
  localparam int unsigned TMO_W          = 17;

  // Reset values
  localparam logic [TICK_W-1:0] TICK_RST = 14'h0000;
  localparam logic [TMO_W-1:0]  CNT_RST  = 17'h00000;

  // Watchdog input sensing
  typedef enum logic [1:0] {
    SSW_WD_FLOAT,
    SSW_WD_LOW,
    SSW_WD_HIGH
  } ssw_wd_level_e;

  // Monitor comparator results, high means below threshold
  typedef struct packed {
    logic primary_low;
    logic secondary_low;
    logic aux_low;
    logic pf_low;
  } ssw_mon_s;

  // Reset supervisor states
  typedef enum logic [1:0] {
    SSW_HOLD,
    SSW_TIMEOUT,
    SSW_RUN
  } ssw_state_e;

endpackage

// [testbench/ssw_host.sv]
// Host model driving the watchdog strobe
`timescale 1ns/1ps
module ssw_host (
  // Clock and controls
  input  wire logic              CLOCK,
  input  wire logic              drive,
  input  wire logic              toggle,
  // Strobe
  output ssw_pkg::ssw_wd_level_e strobe = ssw_pkg::SSW_WD_LOW
);
  int n = 0;
  always @(negedge CLOCK) begin
    n <= n + 1;
    if (!drive)
      strobe <= ssw_pkg::SSW_WD_FLOAT;
    else if (toggle && n % 50 == 0)
      strobe <= (strobe == ssw_pkg::SSW_WD_HIGH) ? ssw_pkg::SSW_WD_LOW : ssw_pkg::SSW_WD_HIGH;
  end
endmodule

// [testbench/ssw_supervisor_asserts.sv]
// Checker bound to the supervisor ports
`timescale 1ns/1ps
module ssw_supervisor_asserts #(
  parameter int unsigned RESET_TICKS    = 1,
  parameter int unsigned WD_LONG_TICKS  = 3,
  parameter int unsigned WD_SHORT_TICKS = 1,
  parameter int unsigned TICK_CYCLES    = 10
) (
  // Clock, reset and inputs
  input wire logic                   CLOCK,
  input wire logic                   RST_N,
  input wire ssw_pkg::ssw_mon_s      MON_BELOW,
  input wire logic                   MANUAL_RESET_N,
  input wire ssw_pkg::ssw_wd_level_e WATCHDOG_STROBE_IN,
  // Outputs
  input wire logic                   PRIMARY_RESET_N,
  input wire logic                   SECONDARY_RESET_N,
  input wire logic                   POWERFAIL_FLAG_N
);
  localparam int T = TICK_CYCLES;
  localparam int RLO = RESET_TICKS * T - 1;
  localparam int RHI = (RESET_TICKS + 1) * T + 3;
  localparam int SLO = (WD_SHORT_TICKS - 1) * T;
  localparam int LLO = (WD_LONG_TICKS - 1) * T;
  int                     cs_q, cp_q, wd_q;
  logic                   seen_q, cs, cp, flt, edg;
  ssw_pkg::ssw_wd_level_e lvl_q;
  assign cs = MON_BELOW.primary_low | MON_BELOW.secondary_low | !MANUAL_RESET_N;
  assign cp = cs | MON_BELOW.aux_low;
  assign flt = WATCHDOG_STROBE_IN == ssw_pkg::SSW_WD_FLOAT;
  assign edg = !flt && lvl_q != ssw_pkg::SSW_WD_FLOAT && WATCHDOG_STROBE_IN != lvl_q;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      cs_q <= 0;
      cp_q <= 0;
      wd_q <= 0;
      seen_q <= 1'b0;
      lvl_q <= ssw_pkg::SSW_WD_FLOAT;
    end else begin
      cs_q <= (cs || SECONDARY_RESET_N) ? 0 : cs_q + 1;
      cp_q <= (cp || PRIMARY_RESET_N) ? 0 : cp_q + 1;
      wd_q <= (!PRIMARY_RESET_N || edg || flt) ? 0 : wd_q + 1;
      seen_q <= PRIMARY_RESET_N && (seen_q || edg);
      lvl_q <= flt ? lvl_q : WATCHDOG_STROBE_IN;
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  sequence s_wd_fire;
    $fell(PRIMARY_RESET_N) && !$past(cp);
  endsequence
  a_sec_cause: assert property (cs |=> !SECONDARY_RESET_N)
    else $error("secondary reset not low on cause");
  a_pri_cause: assert property (cp |=> !PRIMARY_RESET_N)
    else $error("primary reset not low on cause");
  a_pf_follow: assert property (1 |=> POWERFAIL_FLAG_N == !$past(MON_BELOW.pf_low))
    else $error("power fail flag wrong");
  a_sec_no_wd: assert property ($fell(SECONDARY_RESET_N) |-> $past(cs))
    else $error("secondary reset fell without cause");
  a_sec_release: assert property ($rose(SECONDARY_RESET_N) |-> cs_q >= RLO && cs_q <= RHI)
    else $error("secondary release time wrong");
  a_pri_release: assert property ($rose(PRIMARY_RESET_N) |-> cp_q >= RLO && cp_q <= RHI)
    else $error("primary release time wrong");
  a_wd_fire: assert property (s_wd_fire |-> !$past(flt) && wd_q >= (seen_q ? SLO : LLO))
    else $error("watchdog fired early or while floating");
  a_wd_long: assert property (PRIMARY_RESET_N && !seen_q |-> wd_q <= LLO + 2 * T + 3)
    else $error("long watchdog period exceeded");
  a_wd_short: assert property (PRIMARY_RESET_N && seen_q |-> wd_q <= SLO + 2 * T + 3)
    else $error("short watchdog period exceeded");
endmodule
bind ssw_supervisor ssw_supervisor_asserts #(
  .RESET_TICKS(RESET_TICKS), .WD_LONG_TICKS(WD_LONG_TICKS), .WD_SHORT_TICKS(WD_SHORT_TICKS),
  .TICK_CYCLES(TICK_CYCLES)
) u_chk (
  .CLOCK(CLOCK), .RST_N(RST_N), .MON_BELOW(MON_BELOW), .MANUAL_RESET_N(MANUAL_RESET_N),
  .WATCHDOG_STROBE_IN(WATCHDOG_STROBE_IN), .PRIMARY_RESET_N(PRIMARY_RESET_N),
  .SECONDARY_RESET_N(SECONDARY_RESET_N), .POWERFAIL_FLAG_N(POWERFAIL_FLAG_N)
);

// [testbench/ssw_supervisor_tb.sv]
// Self-checking bench for the supervisor
`timescale 1ns/1ps
module ssw_supervisor_tb;
  // Short tick keeps the run brief
  localparam int T = 200;
  logic                   CLOCK = 0;
  logic                   RST_N = 0;
  ssw_pkg::ssw_mon_s      mon = '0;
  logic                   mr_n = 1;
  logic                   drive = 1, toggle = 0, pf_chk = 0, pfb, pfe;
  logic                   pri_n, sec_n, pf_n;
  ssw_pkg::ssw_wd_level_e strobe;
  int                     failures = 0, n_tests = 0, seed = 7, k;
  logic                   pfq[$];
  always #50 CLOCK = ~CLOCK;
  ssw_supervisor #(
    .TICK_CYCLES(T), .RESET_TICKS(1), .WD_LONG_TICKS(3), .WD_SHORT_TICKS(1)
  ) u_dut (
    .CLOCK(CLOCK), .RST_N(RST_N), .MON_BELOW(mon), .MANUAL_RESET_N(mr_n),
    .WATCHDOG_STROBE_IN(strobe), .PRIMARY_RESET_N(pri_n), .SECONDARY_RESET_N(sec_n),
    .POWERFAIL_FLAG_N(pf_n)
  );
  ssw_host u_host (.CLOCK(CLOCK), .drive(drive), .toggle(toggle), .strobe(strobe));
  task automatic chk(logic seen, logic exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Waits for a reset level, k gives cycles taken
  task automatic wt(int w, logic v, int lim);
    k = 0;
    while ((w ? sec_n : pri_n) !== v && k < lim) begin
      @(negedge CLOCK);
      k++;
    end
  endtask
  always @(negedge CLOCK) begin
    pfb = 1'($random(seed));
    mon.pf_low <= pfb;
    pfq.push_back(!pfb);
    if (pfq.size() > 1) begin
      pfe = pfq.pop_front();
      if (pf_chk) chk(pf_n, pfe);
    end
  end
  initial begin
    #(40 * T * 100);
    failures++;
    final_report();
  end
  initial begin
    repeat (3) @(negedge CLOCK);
    RST_N = 1;
    wt(1, 1, 3 * T);
    chk(k >= T - 2 && k <= 2 * T + 5, 1);
    chk(pri_n, 1);
    pf_chk = 1;
    $display("test startup done");
    for (int i = 0; i < 4; i++) begin
      mon.aux_low = i == 0;
      mr_n = i != 1;
      mon.primary_low = i == 2;
      mon.secondary_low = i == 3;
      repeat (5) @(negedge CLOCK);
      chk(pri_n, 0);
      chk(sec_n, i == 0);
      {mon.aux_low, mon.primary_low, mon.secondary_low, mr_n} = 4'h1;
      if (i < 3) repeat (3 * T / 4) @(negedge CLOCK);
    end
    wt(0, 1, 3 * T);
    chk(k >= T - 2 && k <= 2 * T + 5, 1);
    wt(1, 1, 2 * T);
    chk(sec_n, 1);
    $display("test causes done");
    wt(0, 0, 5 * T);
    chk(k >= 3 * T && k <= 4 * T + 5, 1);
    chk(sec_n, 1);
    wt(0, 1, 3 * T);
    chk(k >= T && k <= 2 * T + 5, 1);
    $display("test long watchdog done");
    toggle = 1;
    wt(0, 0, 3 * T);
    chk(pri_n, 1);
    toggle = 0;
    wt(0, 0, 3 * T);
    chk(k <= 2 * T + 5 && pri_n === 1'b0, 1);
    wt(0, 1, 3 * T);
    chk(pri_n, 1);
    $display("test short watchdog done");
    drive = 0;
    wt(0, 0, 4 * T + 100);
    chk(pri_n, 1);
    $display("test float done");
    final_report();
  end
endmodule
